// ==== src/positioning_set_defs.vh ====
`ifndef POSITIONING_SET_DEFS_VH
`define POSITIONING_SET_DEFS_VH

// ----------------------------------------
// Set table size and dedicated sets
// ----------------------------------------
`define N_SETS 259
`define SET_BUS 9'h100
`define SET_JOG_POS 9'h101
`define SET_JOG_NEG 9'h102

// ----------------------------------------
// Start policy and target encoding
// ----------------------------------------
`define POL_IGNORE 2'h0
`define POL_FINISH 2'h1
`define POL_IMMEDIATE 2'h2
`define ENC_ABS 2'h0
`define ENC_REL 2'h1
`define ENC_LAST 2'h2

// ----------------------------------------
// Entry layout: bit offsets and width
// ----------------------------------------
`define F_TGT 0
`define F_ENC 32
`define F_POL 34
`define F_DLY 36
`define F_REM 52
`define F_FF 84
`define F_SYNC 100
`define F_STOP 101
`define F_SPD 102
`define F_FIN 118
`define F_ACC 134
`define F_DEC 150
`define F_JRK 166
`define ENTRY_W 170

// ----------------------------------------
// Field selectors for table writes
// ----------------------------------------
`define WF_TGT 4'h0
`define WF_ENC 4'h1
`define WF_POL 4'h2
`define WF_DLY 4'h3
`define WF_REM 4'h4
`define WF_FF 4'h5
`define WF_SYNC 4'h6
`define WF_STOP 4'h7
`define WF_SPD 4'h8
`define WF_FIN 4'h9
`define WF_ACC 4'hA
`define WF_DEC 4'hB
`define WF_JRK 4'hC

// ----------------------------------------
// State codes (one-hot) and timing
// ----------------------------------------
`define ST_IDLE 3'h1
`define ST_DELAY 3'h2
`define ST_RUN 3'h4
`define CLK_MHZ 125
`define DELAY_UNIT_NS 1000
`define DELAY_CYC ((`DELAY_UNIT_NS * `CLK_MHZ + 999) / 1000)

`endif

// ==== src/positioning_set_sequencer.v ====
`timescale 1ns/1ns
`include "positioning_set_defs.vh"
// Notes on behaviour
// [RL1] Ignore policy: refuse new starts while running
// [RL2] Finish-old policy: queue set, launch after run
// [RL3] Queued relative move references last target
// [RL4] Immediate policy: abort run, take new set
// [RL5] Immediate relative: reference is present setpoint
// [RL6] Immediate last-destination: reference is old target
// [RL7] Wait start delay before moving
// [RL8] Flag when remaining distance reaches set value
// [RL9] Per-set torque feed-forward factor, default zero
// [RL10] Sync active adds master position to setpoint
// [RL11] Saw mode: synced set toggles synchronisation
// [RL12] Stop at nonzero final speed unless queued
// [RL13] Target absolute or relative, chosen per set
// [RL14] Last-destination encoding uses preceding target
// [RL15] Jerk filter smooths acceleration, lengthens run
// [RL16] Long jerk time may miss running speed
// [RL17] Running and final speed; final chains runs
// [RL18] One shared positioning range bounds targets
// [RL19] Separate acceleration and deceleration per set
// [RL20] Start source should be debounced
// [RL21] 256 sets plus fieldbus and jog sets
// [RL22] Absolute target checked against range limits
// [RL23] Start while idle launches after delay
// [RL24] Target reached when setpoint equals target
module positioning_set_sequencer (
  // Clock, reset, enable
  input wire I_CLK,
  input wire I_RST,
  input wire I_CE,
  // Start sources
  input wire I_START_PIN,
  input wire [7:0] I_SET_SEL,
  input wire I_BUS_START,
  input wire I_JOG_POS,
  input wire I_JOG_NEG,
  // Set table write port
  input wire I_WR_EN,
  input wire [8:0] I_WR_IDX,
  input wire [3:0] I_WR_FIELD,
  input wire [31:0] I_WR_DATA,
  // Global configuration
  input wire [31:0] I_POS_MIN,
  input wire [31:0] I_POS_MAX,
  input wire I_SAW_MODE,
  input wire [31:0] I_MASTER_POS,
  // Status and motion outputs
  output reg [31:0] O_SETPOINT,
  output reg [15:0] O_SPEED,
  output reg [31:0] O_TORQUE_FF,
  output reg [8:0] O_ACTIVE_SET,
  output reg O_BUSY,
  output reg O_REACHED,
  output reg O_REM_HIT,
  output reg O_REFUSED,
  output reg O_RANGE_ERR,
  output reg O_SYNC_ACTIVE
);

  // ----------------------------------------
  // Position set table
  // ----------------------------------------
  wire [`ENTRY_W*`N_SETS-1:0] tbl;
  genvar g;
  generate
    for (g = 0; g < `N_SETS; g = g + 1) begin : g_set
      reg [`ENTRY_W-1:0] ent;
      // All fields clear at reset, so feed-forward starts at zero
      always @(posedge I_CLK) begin
        if (I_RST) begin
          ent <= {`ENTRY_W{1'b0}}; // RL9
        end else if (I_CE && I_WR_EN && I_WR_IDX == g) begin // RL21
          case (I_WR_FIELD)
            `WF_TGT: ent[`F_TGT +: 32] <= I_WR_DATA;
            `WF_ENC: ent[`F_ENC +: 2] <= I_WR_DATA[1:0]; // RL13
            `WF_POL: ent[`F_POL +: 2] <= I_WR_DATA[1:0];
            `WF_DLY: ent[`F_DLY +: 16] <= I_WR_DATA[15:0];
            `WF_REM: ent[`F_REM +: 32] <= I_WR_DATA;
            `WF_FF: ent[`F_FF +: 16] <= I_WR_DATA[15:0]; // RL9
            `WF_SYNC: ent[`F_SYNC] <= I_WR_DATA[0];
            `WF_STOP: ent[`F_STOP] <= I_WR_DATA[0];
            `WF_SPD: ent[`F_SPD +: 16] <= I_WR_DATA[15:0]; // RL17
            `WF_FIN: ent[`F_FIN +: 16] <= I_WR_DATA[15:0]; // RL17
            `WF_ACC: ent[`F_ACC +: 16] <= I_WR_DATA[15:0]; // RL19
            `WF_DEC: ent[`F_DEC +: 16] <= I_WR_DATA[15:0]; // RL19
            `WF_JRK: ent[`F_JRK +: 4] <= I_WR_DATA[3:0];
            default: ent <= ent;
          endcase
        end
      end
      assign tbl[g*`ENTRY_W +: `ENTRY_W] = ent;
    end
  endgenerate

  // ----------------------------------------
  // Start pin synchroniser and source select
  // ----------------------------------------
  reg s1, s2, s3, s_stable;
  // Accepted level only changes once the later stages agree
  always @(posedge I_CLK) begin
    if (I_RST) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      s_stable <= 1'b0;
    end else if (I_CE) begin
      s1 <= I_START_PIN;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) s_stable <= s3;
    end
  end
  wire pin_ev = (s2 == s3) && s3 && !s_stable;
  wire st_ev = pin_ev | I_BUS_START | I_JOG_POS | I_JOG_NEG;
  wire [8:0] st_idx = pin_ev ? {1'b0, I_SET_SEL} : I_BUS_START ? `SET_BUS :
                      I_JOG_POS ? `SET_JOG_POS : `SET_JOG_NEG;

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  reg [2:0] state;
  reg [8:0] cur, pend;
  reg pend_v, sync_on, arrive;
  reg [31:0] ref_rel, last_tgt, target, pos;
  reg [23:0] dly;
  reg [16:0] vel;
  reg signed [17:0] accf;

  wire [`ENTRY_W-1:0] ce_ = tbl[cur*`ENTRY_W +: `ENTRY_W];
  wire [`ENTRY_W-1:0] ne = tbl[st_idx*`ENTRY_W +: `ENTRY_W];
  wire [15:0] spd = ce_[`F_SPD +: 16];
  wire [15:0] fin = ce_[`F_FIN +: 16];
  wire [15:0] acc = ce_[`F_ACC +: 16];
  wire [15:0] dec = ce_[`F_DEC +: 16];
  wire [3:0] jrk = ce_[`F_JRK +: 4];
  wire [15:0] fin_eff = (ce_[`F_STOP] && fin != 16'h0000 && !pend_v) ? 16'h0000 : fin; // RL12

  // ----------------------------------------
  // Start arbitration
  // ----------------------------------------
  reg acc_go, acc_pend, acc_ref_last, refuse;
  reg [8:0] acc_idx;
  // A fresh start wins over launching a queued set in the same cycle
  always @* begin
    acc_go = 1'b0;
    acc_pend = 1'b0;
    acc_ref_last = 1'b0;
    refuse = 1'b0;
    acc_idx = st_idx;
    if (st_ev) begin
      if (state == `ST_IDLE) begin
        acc_go = 1'b1; // RL23
      end else begin
        case (ne[`F_POL +: 2])
          `POL_FINISH: acc_pend = 1'b1; // RL2
          `POL_IMMEDIATE: acc_go = 1'b1; // RL4
          default: refuse = 1'b1; // RL1
        endcase
      end
    end else if (state == `ST_RUN && arrive && pend_v) begin
      acc_go = 1'b1; // RL2
      acc_idx = pend;
      acc_ref_last = 1'b1; // RL3
    end
  end
  // Start delay in cycles; 16 bits of microseconds always fit in 24 bits
  wire [15:0] dly_set = acc_ref_last ? tbl[acc_idx*`ENTRY_W + `F_DLY +: 16] : ne[`F_DLY +: 16];
  wire [31:0] dly_full = dly_set * `DELAY_CYC;

  // ----------------------------------------
  // Motion profile generator
  // ----------------------------------------
  reg [32:0] rem, rabs;
  reg neg, brake;
  reg [49:0] lhs;
  reg [33:0] v2;
  reg signed [17:0] cmd, accf_n;
  reg signed [18:0] vn;
  reg [16:0] vclip;
  reg [32:0] step;
  reg [31:0] pos_n, nt;
  // Braking starts once the stopping distance covers what is left
  always @* begin
    rem = {target[31], target} - {pos[31], pos};
    neg = rem[32];
    rabs = neg ? (33'h0 - rem) : rem;
    lhs = {rabs[32:0], 1'b0} * {34'h0, dec};
    v2 = (vel * vel) - ({1'b0, fin_eff} * {1'b0, fin_eff});
    brake = (vel > {1'b0, fin_eff}) && (lhs <= {16'h0000, v2});
    if (brake) cmd = -$signed({2'b00, dec});
    else if (vel < {1'b0, spd}) cmd = $signed({2'b00, acc});
    else if (vel > {1'b0, spd}) cmd = -$signed({2'b00, dec});
    else cmd = 18'sh00000;
    // First-order smoothing of the acceleration; a long filter may never
    // let the speed climb to the programmed value before braking
    accf_n = accf + ((cmd - accf) >>> jrk); // RL15 RL16
    vn = $signed({2'b00, vel}) + accf_n;
    if (vn <= 19'sh00000) vclip = 17'h00001;
    else if (vn > 19'sh0FFFF) vclip = 17'h0FFFF;
    else vclip = vn[16:0];
    step = ({16'h0000, vclip} > rabs) ? rabs : {16'h0000, vclip};
    pos_n = neg ? pos - step[31:0] : pos + step[31:0];
    arrive = (rabs == 33'h0) || (step == rabs);
    // Resolve the commanded target of the current set
    case (ce_[`F_ENC +: 2])
      `ENC_REL: nt = ref_rel + ce_[`F_TGT +: 32]; // RL5 RL13
      `ENC_LAST: nt = last_tgt + ce_[`F_TGT +: 32]; // RL6 RL14
      default: nt = ce_[`F_TGT +: 32]; // RL13
    endcase
  end
  wire range_bad = ($signed(nt) < $signed(I_POS_MIN)) || ($signed(nt) > $signed(I_POS_MAX));

  // ----------------------------------------
  // Sequencer process
  // ----------------------------------------
  always @(posedge I_CLK) begin
    if (I_RST) begin
      state <= `ST_IDLE;
      cur <= 9'h000;
      pend <= 9'h000;
      pend_v <= 1'b0;
      sync_on <= 1'b0;
      ref_rel <= 32'h00000000;
      last_tgt <= 32'h00000000;
      target <= 32'h00000000;
      pos <= 32'h00000000;
      dly <= 24'h000000;
      vel <= 17'h00000;
      accf <= 18'sh00000;
      O_REACHED <= 1'b0;
      O_REFUSED <= 1'b0;
      O_RANGE_ERR <= 1'b0;
    end else if (I_CE) begin
      O_REACHED <= 1'b0;
      O_REFUSED <= refuse; // RL1
      O_RANGE_ERR <= 1'b0;
      // Motion runs toward the current target in any busy state
      if (state != `ST_IDLE && rem != 33'h0) begin
        pos <= pos_n;
        if (arrive) begin
          vel <= {1'b0, fin_eff}; // RL17
          accf <= 18'sh00000;
        end else begin
          vel <= vclip;
          accf <= accf_n;
        end
      end
      if (acc_pend) begin
        pend <= st_idx; // RL2
        pend_v <= 1'b1;
      end
      case (state)
        `ST_IDLE: begin
          vel <= 17'h00000;
          accf <= 18'sh00000;
        end
        `ST_DELAY: begin
          if (dly == 24'h000000) begin
            if (range_bad) begin
              O_RANGE_ERR <= 1'b1; // RL18 RL22
              target <= pos;
              state <= `ST_IDLE;
            end else begin
              target <= nt;
              last_tgt <= nt; // RL14
              state <= `ST_RUN;
              if (I_SAW_MODE && ce_[`F_SYNC]) sync_on <= !sync_on; // RL11
            end
          end else begin
            dly <= dly - 24'h000001; // RL7
          end
        end
        `ST_RUN: begin
          if (arrive && !acc_go) begin
            O_REACHED <= 1'b1; // RL24
            state <= `ST_IDLE;
          end else if (arrive) begin
            O_REACHED <= 1'b1; // RL24
          end
        end
        default: state <= `ST_IDLE;
      endcase
      // Accepted start: note the reference and arm the delay
      if (acc_go) begin
        cur <= acc_idx;
        if (acc_ref_last) pend_v <= 1'b0;
        ref_rel <= acc_ref_last ? last_tgt : pos; // RL3 RL5
        dly <= dly_full[23:0]; // RL7
        state <= `ST_DELAY; // RL4 RL23
      end
    end
  end

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  reg signed [33:0] tq;
  always @* begin
    tq = $signed(ce_[`F_FF +: 16]) * accf; // RL9
  end
  always @(posedge I_CLK) begin
    if (I_RST) begin
      O_SETPOINT <= 32'h00000000;
      O_SPEED <= 16'h0000;
      O_TORQUE_FF <= 32'h00000000;
      O_ACTIVE_SET <= 9'h000;
      O_BUSY <= 1'b0;
      O_REM_HIT <= 1'b0;
      O_SYNC_ACTIVE <= 1'b0;
    end else if (I_CE) begin
      O_SETPOINT <= sync_on ? pos + I_MASTER_POS : pos; // RL10
      O_SPEED <= vel[15:0];
      O_TORQUE_FF <= (state == `ST_RUN) ? tq[31:0] : 32'h00000000; // RL9
      O_ACTIVE_SET <= cur;
      O_BUSY <= (state != `ST_IDLE);
      O_REM_HIT <= (state == `ST_RUN) && (rabs != 33'h0) &&
                   (rabs <= {1'b0, ce_[`F_REM +: 32]}); // RL8
      O_SYNC_ACTIVE <= sync_on;
    end
  end

endmodule

// ==== verification/start_source.sv ====
`timescale 1ns/1ns
// ----------------------------------------
// Debounced start contact
// ----------------------------------------
module start_source (
  // Clock and press request
  input wire logic i_clk,
  input wire logic i_press,
  // Clean start level
  output logic o_pin
);
  logic [3:0] hold = 4'h0;
  // One clean level of 12 cycles, never a bounce, so the pin filter sees a single edge
  always @(posedge i_clk) begin
    if (i_press) begin
      hold <= 4'hC;
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end
  assign o_pin = (hold != 4'h0);
endmodule

// ==== verification/positioning_set_props.sv ====
`timescale 1ns/1ns
module positioning_set_props (
  // Clock and reset
  input wire I_CLK,
  input wire I_RST,
  // Watched signals
  input wire I_BUS_START,
  input wire [31:0] O_TORQUE_FF,
  input wire [8:0] O_ACTIVE_SET,
  input wire O_BUSY,
  input wire O_REACHED,
  input wire O_REM_HIT,
  input wire O_REFUSED,
  input wire O_RANGE_ERR
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  // ----------------------------------------
  // Launch steps
  // ----------------------------------------
  sequence s_launch;
    !O_BUSY && I_BUS_START;
  endsequence
  sequence s_answer;
    ##[1:3] (O_BUSY || O_RANGE_ERR);
  endsequence
  launch_busy_a: assert property (s_launch |-> s_answer)
    else $error("start while idle did not launch");
  refuse_hold_a: assert property (O_REFUSED |-> O_BUSY && $stable(O_ACTIVE_SET))
    else $error("refused start changed the run");
  reach_pulse_a: assert property (O_REACHED |=> !O_REACHED)
    else $error("arrival flag longer than one cycle");
  reach_busy_a: assert property (O_REACHED |-> O_BUSY)
    else $error("arrival flagged outside a run");
  busy_end_a: assert property ($fell(O_BUSY) |-> $past(O_REACHED) || $past(O_REACHED, 2)
    || $past(O_RANGE_ERR) || $past(O_RANGE_ERR, 2))
    else $error("run ended without arrival");
  idle_ff_a: assert property (!O_BUSY && !$past(O_BUSY) |-> O_TORQUE_FF == 32'h0)
    else $error("torque feed-forward while idle");
  rem_run_a: assert property (O_REM_HIT |-> O_BUSY)
    else $error("remaining distance flag outside a run");
  range_pulse_a: assert property (O_RANGE_ERR |=> !O_RANGE_ERR)
    else $error("range error longer than one cycle");
endmodule

bind positioning_set_sequencer positioning_set_props u_positioning_set_props (
  .I_CLK, .I_RST, .I_BUS_START, .O_TORQUE_FF, .O_ACTIVE_SET, .O_BUSY, .O_REACHED,
  .O_REM_HIT, .O_REFUSED, .O_RANGE_ERR);

// ==== verification/positioning_set_sequencer_bench.sv ====
`timescale 1ns/1ns
`include "positioning_set_defs.vh"
module positioning_set_sequencer_bench;
  logic I_CLK = 0, I_RST = 1, I_START_PIN, I_BUS_START = 0, I_JOG_POS = 0, I_JOG_NEG = 0;
  logic I_WR_EN = 0, I_SAW_MODE = 0, press = 0, f, I_CE = 1;
  logic [15:0] spd_at;
  logic [7:0] I_SET_SEL = 8'h00;
  logic [8:0] I_WR_IDX = 9'h000;
  logic [3:0] I_WR_FIELD = 4'h0;
  logic [31:0] I_WR_DATA = 32'h0, I_POS_MIN = 32'h80000000, I_POS_MAX = 32'h7FFFFFFF;
  logic [31:0] I_MASTER_POS = 32'h0, seed = 32'd89779, t, s, p;
  wire [31:0] O_SETPOINT, O_TORQUE_FF;
  wire [15:0] O_SPEED;
  wire [8:0] O_ACTIVE_SET;
  wire O_BUSY, O_REACHED, O_REM_HIT, O_REFUSED, O_RANGE_ERR, O_SYNC_ACTIVE;
  int bad_count = 0, cmp_count = 0, n;
  // ----------------------------------------
  // Design, start contact and clock
  // ----------------------------------------
  positioning_set_sequencer u_positioning_set_sequencer (.I_CLK, .I_RST, .I_CE,
    .I_START_PIN, .I_SET_SEL, .I_BUS_START, .I_JOG_POS, .I_JOG_NEG, .I_WR_EN, .I_WR_IDX,
    .I_WR_FIELD, .I_WR_DATA, .I_POS_MIN, .I_POS_MAX, .I_SAW_MODE, .I_MASTER_POS,
    .O_SETPOINT, .O_SPEED, .O_TORQUE_FF, .O_ACTIVE_SET, .O_BUSY, .O_REACHED, .O_REM_HIT,
    .O_REFUSED, .O_RANGE_ERR, .O_SYNC_ACTIVE);
  start_source u_start_source (.i_clk(I_CLK), .i_press(press), .o_pin(I_START_PIN));
  initial begin
    forever #4 I_CLK = ~I_CLK;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected start wait in cycles for a delay field in microseconds
  function int exp_delay(input int dl);
    return dl * `DELAY_CYC;
  endfunction
  // Inputs move 1 ns after the edge so no race with the design's sampling
  task tick(input int k);
    repeat (k) @(posedge I_CLK);
    #1;
  endtask
  task complete_run();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Strobe stays high across back-to-back writes; the caller lowers it
  task wr(input logic [3:0] fd, input logic [31:0] d);
    I_WR_EN = 1;
    I_WR_FIELD = fd;
    I_WR_DATA = d;
    tick(1);
  endtask
  // Table is cleared at reset, so speed and ramps are loaded with every set
  task cfg(input logic [8:0] ix, input logic [31:0] tg, input logic [1:0] en,
    input logic [1:0] po, input logic [15:0] dl, input logic sy);
    I_WR_IDX = ix;
    wr(`WF_TGT, tg);
    wr(`WF_ENC, {30'h0, en});
    wr(`WF_POL, {30'h0, po});
    wr(`WF_DLY, {16'h0, dl});
    wr(`WF_SYNC, {31'h0, sy});
    wr(`WF_SPD, 32'h40);
    wr(`WF_ACC, 32'h4);
    wr(`WF_DEC, 32'h4);
    wr(`WF_REM, 32'h10);
    I_WR_EN = 0;
  endtask
  task go(input int k);
    if (k == 0) I_BUS_START = 1;
    else if (k == 1) I_JOG_POS = 1;
    else if (k == 2) I_JOG_NEG = 1;
    else press = 1;
    tick(1);
    {I_BUS_START, I_JOG_POS, I_JOG_NEG, press} = 4'h0;
  endtask
  // Bounded wait for arrival, then let the busy flag settle
  task wait_reach();
    n = 0;
    while (O_REACHED !== 1'b1 && n < 30000) begin
      tick(1);
      n++;
    end
    if (n >= 30000) begin
      bad_count++;
      $display("mismatch reached expected 1 seen 0");
      complete_run();
    end
    tick(1);
    spd_at = O_SPEED;
    tick(2);
  endtask
  // A wait that used up its bound ends the run as a failure
  task limit(input int k);
    if (n >= k) begin
      bad_count++;
      $display("mismatch wait expected done seen timeout");
      complete_run();
    end
  endtask
  task seen(output logic fl, input int w);
    fl = 0;
    repeat (4) begin
      fl = fl | (w ? O_RANGE_ERR : O_REFUSED);
      tick(1);
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(6);
    I_RST = 0;
    chk("busy", 0, O_BUSY);
    chk("setpoint", 0, O_SETPOINT);
    t = rnd() % 32'd3000 + 32'd200;
    s = rnd() % 32'd500 + 32'd50;
    cfg(`SET_BUS, t, `ENC_ABS, `POL_IGNORE, 0, 0);
    go(0);
    wait_reach();
    chk("absolute", t, O_SETPOINT);
    chk("active", `SET_BUS, O_ACTIVE_SET);
    cfg(`SET_JOG_POS, s, `ENC_REL, `POL_IGNORE, 0, 0);
    go(1);
    wait_reach();
    chk("relative", t + s, O_SETPOINT);
    // Start delay: setpoint must hold for the whole programmed wait
    cfg(`SET_JOG_NEG, t, `ENC_ABS, `POL_IGNORE, 2, 0);
    go(2);
    n = 0;
    while (O_SETPOINT === t + s && n < 1000) begin
      tick(1);
      n++;
    end
    limit(1000);
    chk("delay", 1, n >= exp_delay(2) && n <= exp_delay(2) + 8);
    wait_reach();
    chk("delayed", t, O_SETPOINT);
    // Ignore policy: second start during a run is refused
    cfg(`SET_BUS, t + 32'd4000, `ENC_ABS, `POL_IGNORE, 0, 0);
    go(0);
    tick(20);
    chk("speed", 32'h40, O_SPEED);
    go(1);
    seen(f, 0);
    chk("refused", 1, f);
    wait_reach();
    chk("ignored", t + 32'd4000, O_SETPOINT);
    // Finish-old policy: queued relative set runs from the last target
    cfg(`SET_BUS, 32'h0, `ENC_ABS, `POL_IGNORE, 0, 0);
    go(0);
    tick(20);
    cfg(`SET_JOG_POS, s, `ENC_REL, `POL_FINISH, 0, 0);
    go(1);
    wait_reach();
    wait_reach();
    chk("queued", s, O_SETPOINT);
    chk("queued set", `SET_JOG_POS, O_ACTIVE_SET);
    // Immediate policy with last-destination reference: no stop at the old target
    cfg(`SET_BUS, s + 32'd5000, `ENC_ABS, `POL_IGNORE, 0, 0);
    go(0);
    tick(20);
    cfg(`SET_JOG_POS, s, `ENC_LAST, `POL_IMMEDIATE, 0, 0);
    go(1);
    wait_reach();
    p = s + s + 32'd5000;
    chk("immediate", p, O_SETPOINT);
    // Narrowed range: out-of-range target is rejected and the axis stays
    I_POS_MAX = 32'd20000;
    cfg(`SET_BUS, 32'd30000, `ENC_ABS, `POL_IGNORE, 0, 0);
    go(0);
    seen(f, 1);
    chk("range", 1, f);
    tick(4);
    chk("stay", p, O_SETPOINT);
    I_POS_MAX = 32'h7FFFFFFF;
    // Flying saw: synced set switches following of the master on, then off
    I_SAW_MODE = 1;
    cfg(`SET_BUS, p + 32'd100, `ENC_ABS, `POL_IGNORE, 0, 1);
    go(0);
    wait_reach();
    chk("sync on", 1, O_SYNC_ACTIVE);
    I_MASTER_POS = 32'd777;
    tick(5);
    chk("follow", p + 32'd877, O_SETPOINT);
    I_MASTER_POS = 32'h0;
    cfg(`SET_BUS, p + 32'd200, `ENC_ABS, `POL_IGNORE, 0, 1);
    go(0);
    wait_reach();
    chk("sync off", 0, O_SYNC_ACTIVE);
    I_SAW_MODE = 0;
    // Pin start of a random table set
    t = rnd();
    I_SET_SEL = t[7:0];
    cfg({1'b0, t[7:0]}, 32'd100, `ENC_ABS, `POL_IGNORE, 0, 0);
    go(3);
    wait_reach();
    chk("pin", 32'd100, O_SETPOINT);
    chk("pin set", {23'h0, t[8:0] & 9'h0FF}, O_ACTIVE_SET);
    // Feed-forward, remaining-distance flag and stop at nonzero final speed
    I_WR_IDX = `SET_BUS;
    wr(`WF_FF, 32'h3);
    wr(`WF_FIN, 32'h20);
    wr(`WF_STOP, 32'h1);
    cfg(`SET_BUS, 32'd2100, `ENC_ABS, `POL_IGNORE, 0, 0);
    go(0);
    tick(8);
    chk("torque", 32'h3 * 32'h4, O_TORQUE_FF);
    n = 0;
    while (O_REM_HIT !== 1'b1 && n < 2000) begin
      tick(1);
      n++;
    end
    limit(2000);
    chk("remaining", 1, 32'd2100 - O_SETPOINT <= 32'h10 && O_SETPOINT != 32'd2100);
    t = n + 8;
    wait_reach();
    t = t + n;
    chk("stop", 0, spd_at);
    // Jerk filter lengthens the reverse move of the same length; a low clock enable freezes it
    wr(`WF_JRK, 32'h2);
    cfg(`SET_BUS, 32'd100, `ENC_ABS, `POL_IGNORE, 0, 0);
    go(0);
    tick(8);
    p = O_SETPOINT;
    I_CE = 0;
    tick(5);
    chk("freeze", p, O_SETPOINT);
    I_CE = 1;
    wait_reach();
    chk("jerk", 1, n + 8 > t);
    // Queued follow-up keeps the final speed instead of stopping
    cfg(`SET_BUS, 32'd3000, `ENC_ABS, `POL_IGNORE, 0, 0);
    go(0);
    tick(20);
    cfg(`SET_JOG_POS, s, `ENC_REL, `POL_FINISH, 0, 0);
    go(1);
    wait_reach();
    chk("chain", 32'h20, spd_at);
    wait_reach();
    chk("chained", 32'd3000 + s, O_SETPOINT);
    complete_run();
  end
endmodule
